// *** core/tpu_pkg.sv ***
// timer/pwm unit package: register offsets, field positions, reset values
// assumes byte offsets as printed are index values, byte address = 4 * index
package tpu_pkg;
   // register indices as printed; apb byte address is four times the index
   localparam logic [7:0] tpu_idx_count = 8'h10;
   localparam logic [7:0] tpu_idx_ctrl_one = 8'h11;
   localparam logic [7:0] tpu_idx_ctrl_two = 8'h12;
   localparam logic [7:0] tpu_idx_duty_one = 8'h13;
   localparam logic [7:0] tpu_idx_pre_count = 8'h14;
   localparam logic [7:0] tpu_idx_pwm_two = 8'h16;
   localparam logic [7:0] tpu_idx_duty_two = 8'h18;
   localparam logic [7:0] tpu_idx_high = 8'h20;
   localparam logic [7:0] tpu_idx_reload_low = 8'h21;
   localparam logic [7:0] tpu_idx_irq_status = 8'h22;
   localparam logic [7:0] tpu_idx_irq_mask = 8'h23;
   // control register one fields
   localparam int tpu_bit_enable = 0;
   localparam int tpu_bit_reload = 1;
   localparam int tpu_bit_one_shot = 2;
   localparam int tpu_bit_polarity = 6;
   localparam int tpu_bit_out_en = 7;
   // control register two fields
   localparam int tpu_bit_pre_dis = 3;
   localparam int tpu_bit_edge = 4;
   localparam int tpu_bit_src = 5;
   // shared high register fields
   localparam int tpu_pos_duty_one_hi = 0;
   localparam int tpu_pos_duty_two_hi = 2;
   localparam int tpu_pos_reload_hi = 4;
   // reset values
   localparam logic [7:0] tpu_rst_ctrl_one = 8'h00;
   localparam logic [5:0] tpu_rst_ctrl_two = 6'h3f;
   localparam logic [7:0] tpu_rst_pre_count = 8'hff;
   localparam logic [9:0] tpu_full_scale = 10'h3ff;
   // interrupt status bit: underflow
   localparam int tpu_irq_underflow = 0;
endpackage : tpu_pkg

// *** core/tpu_prescaler.sv ***
// prescaler: 8-bit down counter stepped by each count pulse, giving one tick per rate period
// assumes a single clock and count pulses that are at most one per cycle
`timescale 1ns/1ns
`default_nettype none
module tpu_prescaler
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cnt_in,
   input wire logic [2:0] rate,
   input wire logic bypass,
   output logic tick,
   output logic [7:0] count_ff
);
   import tpu_pkg::*;
   logic [7:0] nxt_count;
   logic [7:0] mask;

   // lower rate+1 bits wrap to ones once per 2^(rate+1) pulses
   always_comb
   begin
      mask = 8'hff >> (3'd7 - rate);
      nxt_count = count_ff - 8'h01;
      tick = bypass ? cnt_in : (cnt_in && ((count_ff & mask) == 8'h00));
   end

   // counter runs even when bypassed so the value register stays live
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_ff <= tpu_rst_pre_count;
      else if (cnt_in)
         count_ff <= nxt_count;
   end
endmodule // tpu_prescaler
`default_nettype wire

// *** core/tpu_pwm.sv ***
// one pwm channel: compares the timer value against a 10-bit duty value
// assumes the duty value is held steady by the register file
`timescale 1ns/1ns
`default_nettype none
module tpu_pwm
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [9:0] count,
   input wire logic [9:0] duty,
   input wire logic active_low,
   input wire logic out_en,
   output logic pwm_out,
   output logic pwm_oe
);
   import tpu_pkg::*;

   // registered so the pin sees no comparator glitches
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pwm_out <= 1'b0;
         pwm_oe <= 1'b0;
      end
      else
      begin
         pwm_out <= (count <= duty) ^ active_low;
         pwm_oe <= out_en;
      end
   end
endmodule // tpu_pwm
`default_nettype wire

// *** core/tpu_timer.sv ***
// timer/pwm unit: 10-bit down counter, prescaler, two pwm channels, apb slave
// assumes apb master on pclk; ext_count_input synchronous to pclk
// Operation
// - count register read returns low eight bits of the counter
// - count register write loads all ten bits from high field and reload byte
// - counter advances only while its enable bit is set
// - continuous, reload off: on underflow load full scale and continue
// - continuous, reload on: on underflow load reload value and continue
// - one-shot: count down to zero once then stop
// - first channel polarity bit one means active low output
// - first channel enable bit hands its pin to the waveform
// - external clock counts on falling edge when edge bit set, else rising
// - source bit one selects external input, zero the instruction clock
// - first channel period is reload value; duty high bits are [1:0]
// - prescaler value register returns present prescaler count
// - second channel polarity bit one means active low output
// - second channel enable bit hands its pin to the waveform
// - second channel shares period; duty high bits are [3:2]
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module tpu_timer
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_count_input,
   output logic first_pwm_out,
   output logic first_pwm_oe,
   output logic second_pwm_out,
   output logic second_pwm_oe,
   output logic underflow_pulse,
   output logic irq
);
   import tpu_pkg::*;

   typedef enum logic [1:0]
   {
      tpu_st_run = 2'b00,
      tpu_st_done = 2'b01
   } tpu_state_t;

   logic [7:0] ctrl_one_ff;
   logic [5:0] ctrl_two_ff;
   logic [7:0] duty_one_ff;
   logic [7:0] duty_two_ff;
   logic [7:0] second_ctrl_ff;
   logic [5:0] high_ff;
   logic [7:0] reload_low_ff;
   logic [9:0] count_ff;
   logic [9:0] nxt_count;
   logic [0:0] irq_status_ff;
   logic [0:0] irq_mask_ff;
   logic ext_prev_ff;
   tpu_state_t state_ff;
   tpu_state_t nxt_state;
   logic [7:0] pre_value;
   logic pre_tick;
   logic cnt_src;
   logic ext_edge;
   logic wr_en;
   logic rd_en;
   logic mapped;
   logic [9:0] reload_value;

   // word index of an apb byte address; alignment is checked by hit, not here
   function automatic logic [7:0] word_index(input logic [9:0] addr);
      word_index = addr[9:2];
   endfunction

   function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
      hit = (addr[1:0] == 2'b00) && (word_index(addr) == idx);
   endfunction

   // ten-bit value from a two-bit field of the shared high register and a low byte
   function automatic logic [9:0] join_hi(input logic [5:0] hi, input int pos, input logic [7:0] lo);
      join_hi = {hi[pos +: 2], lo};
   endfunction

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign reload_value = join_hi(high_ff, tpu_pos_reload_hi, reload_low_ff);

   // external edge detect; input already synchronous to pclk
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ext_prev_ff <= 1'b0;
      else
         ext_prev_ff <= ext_count_input;
   end

   // count source selection and edge polarity
   always_comb
   begin
      if (ctrl_two_ff[tpu_bit_edge])
         ext_edge = ext_prev_ff && !ext_count_input;
      else
         ext_edge = !ext_prev_ff && ext_count_input;
      cnt_src = ctrl_two_ff[tpu_bit_src] ? ext_edge : 1'b1;
   end

   // prescaler ticks only while the timer is enabled
   tpu_prescaler u_pre
   (
      .pclk(pclk),
      .presetn(presetn),
      .cnt_in(cnt_src && ctrl_one_ff[tpu_bit_enable]),
      .rate(ctrl_two_ff[2:0]),
      .bypass(ctrl_two_ff[tpu_bit_pre_dis]),
      .tick(pre_tick),
      .count_ff(pre_value)
   );

   // down counter next value and mode handling
   always_comb
   begin
      nxt_count = count_ff;
      nxt_state = state_ff;
      underflow_pulse = 1'b0;
      case (state_ff)
         tpu_st_run:
         begin
            if (ctrl_one_ff[tpu_bit_enable] && pre_tick)
            begin
               if (count_ff == 10'h000)
               begin
                  underflow_pulse = 1'b1;
                  if (ctrl_one_ff[tpu_bit_one_shot])
                     nxt_state = tpu_st_done;
                  else if (ctrl_one_ff[tpu_bit_reload])
                     nxt_count = reload_value;
                  else
                     nxt_count = tpu_full_scale;
               end
               else
                  nxt_count = count_ff - 10'h001;
            end
         end
         tpu_st_done:
            nxt_state = tpu_st_done;
         default:
            nxt_state = tpu_st_run;
      endcase
      // a count write restarts the counter, also out of a finished one-shot
      if (wr_en && hit(paddr, tpu_idx_count))
      begin
         nxt_count = join_hi(high_ff, tpu_pos_reload_hi, pwdata[7:0]);
         nxt_state = tpu_st_run;
      end
   end

   // down counter; full scale after reset so a first free run spans the whole range
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_ff <= tpu_full_scale;
      else
         count_ff <= nxt_count;
   end

   // run or finished one-shot
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_ff <= tpu_st_run;
      else
         state_ff <= nxt_state;
   end

   // control register one; unused bits 5:3 always read zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_one_ff <= tpu_rst_ctrl_one;
      else if (wr_en && hit(paddr, tpu_idx_ctrl_one))
         ctrl_one_ff <= pwdata[7:0] & 8'hc7;
   end

   // control register two
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_two_ff <= tpu_rst_ctrl_two;
      else if (wr_en && hit(paddr, tpu_idx_ctrl_two))
         ctrl_two_ff <= pwdata[5:0]; // rate change while running may glitch a tick
   end

   // first duty byte, write only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         duty_one_ff <= 8'h00;
      else if (wr_en && hit(paddr, tpu_idx_duty_one))
         duty_one_ff <= pwdata[7:0];
   end

   // second duty byte, write only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         duty_two_ff <= 8'h00;
      else if (wr_en && hit(paddr, tpu_idx_duty_two))
         duty_two_ff <= pwdata[7:0];
   end

   // second channel control; only enable and polarity are kept
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         second_ctrl_ff <= 8'h00;
      else if (wr_en && hit(paddr, tpu_idx_pwm_two))
         second_ctrl_ff <= pwdata[7:0] & 8'hc0;
   end

   // shared high bits of both duty values and of the reload value
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         high_ff <= 6'h00;
      else if (wr_en && hit(paddr, tpu_idx_high))
         high_ff <= pwdata[5:0];
   end

   // reload byte; a count write stores its byte here too, so reload mode repeats it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reload_low_ff <= 8'h00;
      else if (wr_en && (hit(paddr, tpu_idx_reload_low) || hit(paddr, tpu_idx_count)))
         reload_low_ff <= pwdata[7:0];
   end

   // interrupt mask
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_mask_ff <= 1'b0;
      else if (wr_en && hit(paddr, tpu_idx_irq_mask))
         irq_mask_ff <= pwdata[0:0];
   end

   // sticky underflow flag; a new event wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_status_ff <= 1'b0;
      else if (underflow_pulse)
         irq_status_ff <= 1'b1;
      else if (wr_en && hit(paddr, tpu_idx_irq_status) && pwdata[tpu_irq_underflow])
         irq_status_ff <= 1'b0;
   end

   assign irq = |(irq_status_ff & irq_mask_ff);

   // read mux; duty registers are write-only and read as zero
   always_comb
   begin
      mapped = 1'b1;
      prdata = 32'h0000_0000;
      if (hit(paddr, tpu_idx_count))
         prdata[7:0] = count_ff[7:0];
      else if (hit(paddr, tpu_idx_ctrl_one))
         prdata[7:0] = ctrl_one_ff;
      else if (hit(paddr, tpu_idx_ctrl_two))
         prdata[5:0] = ctrl_two_ff;
      else if (hit(paddr, tpu_idx_pre_count))
         prdata[7:0] = pre_value;
      else if (hit(paddr, tpu_idx_pwm_two))
         prdata[7:0] = second_ctrl_ff;
      else if (hit(paddr, tpu_idx_high))
         prdata[5:0] = high_ff;
      else if (hit(paddr, tpu_idx_reload_low))
         prdata[7:0] = reload_low_ff;
      else if (hit(paddr, tpu_idx_irq_status))
         prdata[0] = irq_status_ff[0];
      else if (hit(paddr, tpu_idx_irq_mask))
         prdata[0] = irq_mask_ff[0];
      else if (!hit(paddr, tpu_idx_duty_one) && !hit(paddr, tpu_idx_duty_two))
         mapped = 1'b0;
      pslverr = psel && penable && !mapped;
      if (!rd_en)
         prdata = 32'h0000_0000;
   end

   // first channel: duty high bits [1:0], period from shared reload
   tpu_pwm u_pwm_one
   (
      .pclk(pclk),
      .presetn(presetn),
      .count(count_ff),
      .duty(join_hi(high_ff, tpu_pos_duty_one_hi, duty_one_ff)),
      .active_low(ctrl_one_ff[tpu_bit_polarity]),
      .out_en(ctrl_one_ff[tpu_bit_out_en]),
      .pwm_out(first_pwm_out),
      .pwm_oe(first_pwm_oe)
   );

   // second channel: duty high bits [3:2], same frame
   tpu_pwm u_pwm_two
   (
      .pclk(pclk),
      .presetn(presetn),
      .count(count_ff),
      .duty(join_hi(high_ff, tpu_pos_duty_two_hi, duty_two_ff)),
      .active_low(second_ctrl_ff[tpu_bit_polarity]),
      .out_en(second_ctrl_ff[tpu_bit_out_en]),
      .pwm_out(second_pwm_out),
      .pwm_oe(second_pwm_oe)
   );
endmodule // tpu_timer
`default_nettype wire

// *** tb/tpu_timer_properties.sv ***
// checker: mode-aware timing relations at the timer/pwm unit's ports
// assumes pready tied high, so every access phase ends a transfer
`timescale 1ns/1ns
`default_nettype none
module tpu_timer_properties
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic underflow_pulse,
   input wire logic irq,
   input wire logic first_pwm_oe,
   input wire logic second_pwm_oe
);
   logic wr, mask_wr, run, mk_ff, seen_ff;
   logic [7:0] c1_ff, c2_ff, p2_ff, hi_ff, rl_ff;
   logic [19:0] gap_ff, per;
   // period only judged between two pulses with no write in between
   assign wr = psel && penable && pwrite;
   assign mask_wr = wr && paddr == 10'h08c;
   assign run = underflow_pulse && seen_ff && c1_ff[0] && !c1_ff[2] && !c2_ff[5];
   assign per = c1_ff[1] ? {10'h000, hi_ff[5:4], rl_ff} + 20'h00001 : 20'h00400;
   // shadow registers follow the write stream
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         {c1_ff, p2_ff, hi_ff, rl_ff, mk_ff} <= 33'h0;
         c2_ff <= 8'h3f;
      end
      else if (wr)
         case (paddr)
            10'h044: c1_ff <= pwdata[7:0];
            10'h048: c2_ff <= pwdata[7:0];
            10'h058: p2_ff <= pwdata[7:0];
            10'h080: hi_ff <= pwdata[7:0];
            10'h040, 10'h084: rl_ff <= pwdata[7:0];
            10'h08c: mk_ff <= pwdata[0];
            default: ;
         endcase
   // cycles since the last underflow
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         gap_ff <= 20'h00000;
         seen_ff <= 1'b0;
      end
      else
      begin
         gap_ff <= underflow_pulse ? 20'h00001 : gap_ff + 20'h00001;
         seen_ff <= underflow_pulse || (seen_ff && !wr);
      end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   period_bypass_a: assert property (run && c2_ff[3] |-> gap_ff == per)
      else $error("bypassed period wrong");
   period_scaled_a: assert property (run && !c2_ff[3] |-> gap_ff == per << c2_ff[2:0] << 1)
      else $error("prescaled period wrong");
   halt_stops_a: assert property (wr && paddr == 10'h044 && !pwdata[0] |=> !underflow_pulse [*2])
      else $error("event while halted");
   oneshot_stop_a: assert property (underflow_pulse && c1_ff[0] && c1_ff[2] |=> !underflow_pulse [*8])
      else $error("one-shot kept counting");
   event_irq_a: assert property (underflow_pulse && mk_ff |=> irq)
      else $error("event did not raise irq");
   irq_cause_a: assert property ($rose(irq) |-> $past(underflow_pulse) || $past(mask_wr))
      else $error("irq rose without cause");
   first_oe_a: assert property ($stable(c1_ff) && c1_ff == $past(c1_ff, 2) |-> first_pwm_oe == c1_ff[7])
      else $error("first enable mismatch");
   second_oe_a: assert property ($stable(p2_ff) && p2_ff == $past(p2_ff, 2) |-> second_pwm_oe == p2_ff[7])
      else $error("second enable mismatch");
endmodule // tpu_timer_properties
bind tpu_timer tpu_timer_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .irq(irq),
   .underflow_pulse(underflow_pulse), .first_pwm_oe(first_pwm_oe), .second_pwm_oe(second_pwm_oe));
`default_nettype wire

// *** tb/tpu_pin_model.sv ***
// pin model: external count source and the two pwm pin loads
// assumes drive() is called just after a rising clock edge
`timescale 1ns/1ns
`default_nettype none
module tpu_pin_model
#(
   parameter logic port_level = 1'b1
)
(
   input wire logic pclk,
   input wire logic first_pwm_out,
   input wire logic first_pwm_oe,
   input wire logic second_pwm_out,
   input wire logic second_pwm_oe,
   output logic ext_count_input,
   output logic first_pin,
   output logic second_pin
);
   // a released pin falls back to the port latch, not the last waveform level
   assign first_pin = first_pwm_oe ? first_pwm_out : port_level;
   assign second_pin = second_pwm_oe ? second_pwm_out : port_level;
   initial ext_count_input = 1'b0;
   // one level change, held so the unit sees a single clean edge
   task automatic drive(input logic lvl);
      ext_count_input <= lvl;
      repeat (4) @(posedge pclk);
   endtask
endmodule // tpu_pin_model
`default_nettype wire

// *** tb/testbench.sv ***
// testbench: register, timing and pwm scenarios for the timer/pwm unit
// assumes the checker is bound to the unit and the pin model sits on its far side
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import tpu_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext, irq, uf;
   logic o1, e1, o2, e2, pin1, pin2, err;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int miscompares, n_compared, n;
   tpu_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_count_input(ext), .first_pwm_out(o1), .first_pwm_oe(e1),
      .second_pwm_out(o2), .second_pwm_oe(e2), .underflow_pulse(uf), .irq(irq));
   tpu_pin_model pins (.pclk(pclk), .first_pwm_out(o1), .first_pwm_oe(e1), .first_pin(pin1),
      .second_pwm_out(o2), .second_pwm_oe(e2), .second_pin(pin2), .ext_count_input(ext));
   // 10 mhz clock
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic results;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; an idle edge first keeps psel from being driven twice
   task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
      int k;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, i, 2'b00, d};
      @(posedge pclk);
      penable <= 1'b1;
      // request stands until an edge samples pready high; read data is taken there
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1)
      begin
         miscompares++;
         results();
      end
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic rdchk(input logic [7:0] i, input logic [31:0] exp);
      bus(1'b0, i, 32'h0);
      check(rd, exp);
   endtask
   // counts edges up to and including the next underflow; a hang fails when required
   task automatic wait_uf(input int lim, input bit must);
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (uf !== 1'b1 && n < lim);
      if (must && uf !== 1'b1)
      begin
         miscompares++;
         results();
      end
   endtask
   task automatic t_reset;
      rdchk(tpu_idx_ctrl_two, 32'h3f);
      rdchk(tpu_idx_pre_count, 32'hff);
      rdchk(tpu_idx_count, 32'hff);
      rdchk(tpu_idx_duty_one, 32'h0);
      rdchk(8'hff, 32'h0);
      check(err, 1'b1);
      $display("reset test done");
   endtask
   task automatic t_reload;
      bus(1'b1, tpu_idx_ctrl_two, 32'h08);
      bus(1'b1, tpu_idx_count, 32'h05);
      bus(1'b1, tpu_idx_irq_mask, 32'h1);
      bus(1'b1, tpu_idx_ctrl_one, 32'h03);
      wait_uf(64, 1);
      wait_uf(64, 1);
      check(n, 6);
      bus(1'b1, tpu_idx_ctrl_one, 32'h01);
      wait_uf(64, 1);
      wait_uf(1100, 1);
      check(n, 1024);
      bus(1'b1, tpu_idx_ctrl_one, 32'h00);
      bus(1'b1, tpu_idx_irq_mask, 32'h0);
      @(negedge pclk);
      check(irq, 1'b0);
      bus(1'b1, tpu_idx_irq_mask, 32'h1);
      @(negedge pclk);
      check(irq, 1'b1);
      bus(1'b1, tpu_idx_irq_status, 32'h1);
      @(negedge pclk);
      check(irq, 1'b0);
      $display("reload test done");
   endtask
   task automatic t_oneshot;
      bus(1'b1, tpu_idx_count, 32'h03);
      bus(1'b1, tpu_idx_ctrl_one, 32'h07);
      wait_uf(16, 1);
      wait_uf(40, 0);
      check(n, 40);
      rdchk(tpu_idx_count, 32'h00);
      bus(1'b1, tpu_idx_ctrl_one, 32'h00);
      $display("one-shot test done");
   endtask
   task automatic t_prescale;
      bus(1'b1, tpu_idx_count, 32'h00);
      for (int r = 0; r < 8; r++)
      begin
         bus(1'b1, tpu_idx_ctrl_two, 32'h08 | r);
         bus(1'b1, tpu_idx_ctrl_two, r);
         bus(1'b1, tpu_idx_ctrl_one, 32'h03);
         wait_uf(600, 1);
         wait_uf(600, 1);
         check(n, 32'h2 << r);
         bus(1'b1, tpu_idx_ctrl_one, 32'h00);
         bus(1'b1, tpu_idx_ctrl_two, 32'h08 | r);
      end
      $display("prescale test done");
   endtask
   task automatic t_pwm;
      logic [7:0] c;
      for (int k = 0; k < 6; k++)
      begin
         c = 8'h7f + 8'(k % 3);
         bus(1'b1, tpu_idx_high, k < 3 ? 32'h19 : 32'h11);
         bus(1'b1, tpu_idx_duty_one, 32'h80);
         bus(1'b1, tpu_idx_duty_two, 32'h80);
         bus(1'b1, tpu_idx_ctrl_one, {24'h0, 1'b1, k[0], 6'h00});
         bus(1'b1, tpu_idx_pwm_two, {24'h0, 1'b1, k[1], 6'h00});
         bus(1'b1, tpu_idx_count, c);
         repeat (2) @(posedge pclk);
         @(negedge pclk);
         check({e1, pin1}, {1'b1, (c <= 8'h80) ^ k[0]});
         check({e2, pin2}, {1'b1, (k < 3) ^ k[1]});
      end
      bus(1'b1, tpu_idx_ctrl_one, 32'h00);
      bus(1'b1, tpu_idx_pwm_two, 32'h00);
      repeat (2) @(posedge pclk);
      check({e1, e2, pin1, pin2}, 4'b0011);
      $display("pwm test done");
   endtask
   task automatic t_ext;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int e = 0; e < 2; e++)
      begin
         bus(1'b1, tpu_idx_ctrl_two, e ? 32'h3f : 32'h2f);
         bus(1'b1, tpu_idx_count, 32'h10);
         bus(1'b1, tpu_idx_ctrl_one, 32'h01);
         pins.drive(1'b1);
         rdchk(tpu_idx_count, e ? 32'h10 : 32'h0f);
         pins.drive(1'b0);
         rdchk(tpu_idx_count, 32'h0f);
      end
      $display("external clock test done");
   endtask
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = 46'h0;
      miscompares = 0;
      n_compared = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_reload();
      t_oneshot();
      t_prescale();
      t_pwm();
      t_ext();
      results();
   end
endmodule // testbench
`default_nettype wire
